// >>> logic/telem_pkg.sv
`default_nettype none
package telem_pkg;
	// Command codes
	localparam logic [7:0] CMD_PAGE = 8'h00;
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] CMD_STORE_USER_ALL = 8'h15;
	localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
	localparam logic [7:0] CMD_STATUS_CML = 8'h7e;
	localparam logic [7:0] CMD_OUTPUT_CURRENT = 8'h8c;
	localparam logic [7:0] CMD_EXT_TEMPERATURE = 8'h8e;
	localparam logic [7:0] CMD_PROTOCOL_REVISION = 8'h98;
	localparam logic [7:0] CMD_USER_SCRATCH = 8'hd0;
	localparam logic [7:0] CMD_REF_TRIM = 8'hd4;
	// Linear format fields
	localparam logic [4:0] IOUT_EXPONENT = 5'h1c;
	localparam logic [4:0] TEMP_EXPONENT = 5'h00;
	localparam logic [15:0] IOUT_RESET = 16'he000;
	localparam logic [15:0] TEMP_RESET = 16'h0019;
	localparam logic [15:0] SCRATCH_RESET = 16'h0000;
	localparam logic [15:0] TRIM_RESET = 16'h0000;
	// Trim limits in 2 mV counts
	localparam int TRIM_STEP_MV = 2;
	localparam int TRIM_MIN_MV = -120;
	localparam int TRIM_MAX_MV = 60;
	localparam int NET_MIN_MV = -180;
	localparam int NET_MAX_MV = 60;
	localparam logic signed [16:0] TRIM_MIN = 17'(TRIM_MIN_MV / TRIM_STEP_MV);
	localparam logic signed [16:0] TRIM_MAX = 17'(TRIM_MAX_MV / TRIM_STEP_MV);
	localparam logic signed [16:0] NET_MIN = 17'(NET_MIN_MV / TRIM_STEP_MV);
	localparam logic signed [16:0] NET_MAX = 17'(NET_MAX_MV / TRIM_STEP_MV);
	// Status bit positions
	localparam int STATUS_BYTE_CML_BIT = 1;
	localparam int STATUS_CML_BAD_DATA_BIT = 6;
	localparam int STATUS_CML_BAD_CMD_BIT = 7;
	// Link framing
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [15:0] UNMAPPED_READ = 16'hffff;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RX = 3'b001,
		ST_RX_ACK = 3'b010,
		ST_TX = 3'b011,
		ST_TX_ACK = 3'b100
	} link_state_t;
endpackage
`default_nettype wire

// >>> logic/telemetry_trim_registers.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Paged output-current command returns selected channel's current as linear word.
// - Output-current exponent fixed at minus four, 62.5 mA per count.
// - Low ten mantissa bits carry the channel's current conversion.
// - Eleventh mantissa bit zero; negative current reads as zero.
// - Paged external-temperature command returns selected channel's temperature word.
// - Temperature exponent zero; low eleven mantissa bits carry conversion.
// - Temperature reads twenty-five before any conversion arrives.
// - Revision command returns one constant read-only byte.
// - Sixteen-bit scratch word, read/write, reset zero, no side effect.
// - Store-all command copies scratch word to non-volatile store.
// - Trim adds trim times 2 mV to reference; stored by store-all.
// - Trim outside -120..+60 mV clamps, raises alert, CML and bad-data bits.
// - Trim plus margin limited to -180..+60 mV, clamps and flags alike.
// - Reference change during soft-start ramps at programmed rise slope.
// - Reference change after soft-start ramps at slowest rise slope.
// - Bad-data flag is bit 6 of communication status.
module telemetry_trim_registers
	import telem_pkg::*;
#(
	parameter int CHANNELS = 2,
	parameter logic [6:0] BUS_ADDRESS = 7'h24,
	// Arbitrary value
	parameter logic [7:0] REVISION_CODE = 8'h5a
)
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RESETN,
	// Bus pins
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	output logic ALERT_OUT,
	output logic ALERT_OE,
	// Conversion results
	input wire logic [CHANNELS-1:0] IOUT_VALID,
	input wire logic [CHANNELS-1:0][9:0] IOUT_CODE,
	input wire logic [CHANNELS-1:0] IOUT_NEGATIVE,
	input wire logic [CHANNELS-1:0] TEMP_VALID,
	input wire logic [CHANNELS-1:0][10:0] TEMP_CODE,
	// Reference control
	input wire logic [CHANNELS-1:0][15:0] MARGIN_STEP_SETTING,
	input wire logic [CHANNELS-1:0] SOFT_START_DONE,
	output logic [CHANNELS-1:0][15:0] REF_OFFSET,
	output logic [CHANNELS-1:0] RAMP_USE_TON_RISE,
	output logic [CHANNELS-1:0] RAMP_USE_SLOWEST,
	// Non-volatile store
	output logic STORE_PULSE,
	output logic [15:0] STORE_SCRATCH,
	output logic [CHANNELS-1:0][15:0] STORE_TRIM
);
	localparam int PW = (CHANNELS > 1) ? $clog2(CHANNELS) : 1;
	// ----------------------------------------
	// Pin synchronisers and edge detect
	// ----------------------------------------
	logic scl_s1_reg, scl_s2_reg, scl_d_reg, sda_s1_reg, sda_s2_reg, sda_d_reg;
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			{scl_s1_reg, scl_s2_reg, scl_d_reg, sda_s1_reg, sda_s2_reg, sda_d_reg} <= 6'h3f;
		else
			{scl_s1_reg, scl_s2_reg, scl_d_reg, sda_s1_reg, sda_s2_reg, sda_d_reg} <=
				{SCL_IN, scl_s1_reg, scl_s2_reg, SDA_IN, sda_s1_reg, sda_s2_reg};
	end
	wire scl_rise = scl_s2_reg & ~scl_d_reg;
	wire scl_fall = ~scl_s2_reg & scl_d_reg;
	wire start_ev = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
	wire stop_ev = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

	// ----------------------------------------
	// Link state
	// ----------------------------------------
	link_state_t state_reg;
	logic [7:0] shift_reg, tx_reg, cmd_reg;
	logic [3:0] bit_cnt_reg;
	logic [1:0] byte_idx_reg, data_cnt_reg;
	logic rd_idx_reg, read_reg, have_cmd_reg, nack_reg, oe_reg;
	logic [15:0] data_reg, scratch_reg;
	logic [PW-1:0] page_reg;
	logic [CHANNELS-1:0][15:0] iout_reg, temp_reg, trim_reg;
	logic cml_reg, bad_data_reg, bad_cmd_reg, store_reg;
	// Read mux: paged items follow the page, shared ones do not
	wire [15:0] rd_word =
		(cmd_reg == CMD_OUTPUT_CURRENT) ? iout_reg[page_reg] :
		(cmd_reg == CMD_EXT_TEMPERATURE) ? temp_reg[page_reg] :
		(cmd_reg == CMD_PROTOCOL_REVISION) ? {8'h00, REVISION_CODE} :
		(cmd_reg == CMD_USER_SCRATCH) ? scratch_reg :
		(cmd_reg == CMD_REF_TRIM) ? trim_reg[page_reg] :
		(cmd_reg == CMD_PAGE) ? 16'(page_reg) :
		(cmd_reg == CMD_STATUS_BYTE) ? 16'({cml_reg, 1'b0} << (STATUS_BYTE_CML_BIT - 1)) :
		(cmd_reg == CMD_STATUS_CML) ? {8'h00, bad_cmd_reg, bad_data_reg, 6'h00} :
		UNMAPPED_READ;
	wire [15:0] rd_next_byte = rd_idx_reg ? {8'h00, rd_word[15:8]} : {8'h00, rd_word[7:0]};
	wire [7:0] tx_first = rd_next_byte[7:0];
	wire addr_hit = (shift_reg[7:1] == BUS_ADDRESS);
	wire byte_done = scl_fall && (bit_cnt_reg == BITS_PER_BYTE);
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			state_reg <= ST_IDLE;
			shift_reg <= 8'h00;
			tx_reg <= 8'h00;
			cmd_reg <= 8'h00;
			bit_cnt_reg <= 4'h0;
			byte_idx_reg <= 2'h0;
			data_cnt_reg <= 2'h0;
			rd_idx_reg <= 1'b0;
			read_reg <= 1'b0;
			have_cmd_reg <= 1'b0;
			nack_reg <= 1'b0;
			oe_reg <= 1'b0;
			data_reg <= 16'h0000;
		end
		else if (start_ev)
		begin
			// Repeated start keeps the command for the read phase
			state_reg <= ST_RX;
			bit_cnt_reg <= 4'h0;
			byte_idx_reg <= 2'h0;
			oe_reg <= 1'b0;
		end
		else if (stop_ev)
		begin
			state_reg <= ST_IDLE;
			oe_reg <= 1'b0;
			have_cmd_reg <= 1'b0;
		end
		else
		begin
			case (state_reg)
				ST_RX:
				begin
					if (scl_rise)
					begin
						shift_reg <= {shift_reg[6:0], sda_s2_reg};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end
					else if (byte_done)
					begin
						if (byte_idx_reg == 2'h0)
						begin
							read_reg <= shift_reg[0];
							rd_idx_reg <= 1'b0;
							oe_reg <= addr_hit;
							state_reg <= addr_hit ? ST_RX_ACK : ST_IDLE;
						end
						else
						begin
							if (byte_idx_reg == 2'h1 && !have_cmd_reg)
							begin
								cmd_reg <= shift_reg;
								have_cmd_reg <= 1'b1;
								data_cnt_reg <= 2'h0;
							end
							else
							begin
								// Low byte first, then high byte
								data_reg <= (data_cnt_reg == 2'h0) ? {8'h00, shift_reg} : {shift_reg, data_reg[7:0]};
								data_cnt_reg <= (data_cnt_reg == 2'h3) ? 2'h3 : data_cnt_reg + 2'h1;
							end
							oe_reg <= 1'b1;
							state_reg <= ST_RX_ACK;
						end
						byte_idx_reg <= (byte_idx_reg == 2'h3) ? 2'h3 : byte_idx_reg + 2'h1;
					end
				end
				ST_RX_ACK:
				begin
					if (scl_fall)
					begin
						bit_cnt_reg <= 4'h0;
						if (read_reg)
						begin
							tx_reg <= tx_first;
							oe_reg <= ~tx_first[7];
							state_reg <= ST_TX;
						end
						else
						begin
							oe_reg <= 1'b0;
							state_reg <= ST_RX;
						end
					end
				end
				ST_TX:
				begin
					if (scl_fall)
					begin
						tx_reg <= {tx_reg[6:0], 1'b0};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
						if (bit_cnt_reg == BITS_PER_BYTE - 4'h1)
						begin
							oe_reg <= 1'b0;
							rd_idx_reg <= 1'b1;
							state_reg <= ST_TX_ACK;
						end
						else
							oe_reg <= ~tx_reg[6];
					end
				end
				ST_TX_ACK:
				begin
					if (scl_rise)
						nack_reg <= sda_s2_reg;
					else if (scl_fall)
					begin
						bit_cnt_reg <= 4'h0;
						if (nack_reg)
							state_reg <= ST_IDLE;
						else
						begin
							tx_reg <= tx_first;
							oe_reg <= ~tx_first[7];
							state_reg <= ST_TX;
						end
					end
				end
				default:
					oe_reg <= 1'b0;
			endcase
		end
	end
	// ----------------------------------------
	// Write commit at stop
	// ----------------------------------------
	// Commands act only once the whole packet is in, so a torn write changes nothing
	wire commit = stop_ev && have_cmd_reg && !read_reg;
	wire is_send = commit && (data_cnt_reg == 2'h0);
	wire is_byte = commit && (data_cnt_reg == 2'h1);
	wire is_word = commit && (data_cnt_reg == 2'h2);
	wire wr_page = is_byte && (cmd_reg == CMD_PAGE);
	wire page_ok = (32'(data_reg[7:0]) < CHANNELS);
	wire wr_scratch = is_word && (cmd_reg == CMD_USER_SCRATCH);
	wire wr_trim = is_word && (cmd_reg == CMD_REF_TRIM);
	wire do_store = is_send && (cmd_reg == CMD_STORE_USER_ALL);
	wire do_clear = is_send && (cmd_reg == CMD_CLEAR_FAULTS);
	wire known_cmd = (cmd_reg == CMD_PAGE) || (cmd_reg == CMD_USER_SCRATCH) || (cmd_reg == CMD_REF_TRIM) ||
		(cmd_reg == CMD_STORE_USER_ALL) || (cmd_reg == CMD_CLEAR_FAULTS);
	wire bad_cmd_ev = commit && !known_cmd;
	// Clamp of the written trim
	wire signed [16:0] trim_in = {data_reg[15], data_reg};
	wire trim_low = trim_in < TRIM_MIN;
	wire trim_high = trim_in > TRIM_MAX;
	wire [15:0] trim_clamped = trim_low ? TRIM_MIN[15:0] : trim_high ? TRIM_MAX[15:0] : data_reg;
	wire trim_bad = wr_trim && (trim_low || trim_high);
	// ----------------------------------------
	// Per-channel telemetry and reference
	// ----------------------------------------
	logic [CHANNELS-1:0] net_bad;
	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++)
		begin : g_ch
			wire signed [16:0] net_sum = 17'(signed'(trim_reg[ch])) + 17'(signed'(MARGIN_STEP_SETTING[ch]));
			wire net_low = net_sum < NET_MIN;
			wire net_high = net_sum > NET_MAX;
			wire [15:0] net_word = net_low ? NET_MIN[15:0] : net_high ? NET_MAX[15:0] : net_sum[15:0];
			logic [15:0] ref_reg;
			assign net_bad[ch] = net_low | net_high;
			assign REF_OFFSET[ch] = ref_reg;
			assign RAMP_USE_TON_RISE[ch] = ~SOFT_START_DONE[ch];
			assign RAMP_USE_SLOWEST[ch] = SOFT_START_DONE[ch];
			always_ff @(posedge CLK or negedge RESETN)
			begin
				if (!RESETN)
				begin
					iout_reg[ch] <= IOUT_RESET;
					temp_reg[ch] <= TEMP_RESET;
					trim_reg[ch] <= TRIM_RESET;
					ref_reg <= TRIM_RESET;
				end
				else
				begin
					// Current gain and offset trimming lies upstream of the code
					if (IOUT_VALID[ch])
						iout_reg[ch] <= {IOUT_EXPONENT, 1'b0, IOUT_NEGATIVE[ch] ? 10'h000 : IOUT_CODE[ch]};
					if (TEMP_VALID[ch])
						temp_reg[ch] <= {TEMP_EXPONENT, TEMP_CODE[ch]};
					if (wr_trim && (32'(page_reg) == ch))
						trim_reg[ch] <= trim_clamped;
					ref_reg <= net_word;
				end
			end
		end
	endgenerate
	// ----------------------------------------
	// Shared registers and status
	// ----------------------------------------
	wire bad_data_ev = trim_bad || (|net_bad) || (wr_page && !page_ok);
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			page_reg <= '0;
			scratch_reg <= SCRATCH_RESET;
			cml_reg <= 1'b0;
			bad_data_reg <= 1'b0;
			bad_cmd_reg <= 1'b0;
			store_reg <= 1'b0;
			STORE_SCRATCH <= SCRATCH_RESET;
			STORE_TRIM <= '0;
		end
		else
		begin
			if (wr_page && page_ok)
				page_reg <= data_reg[PW-1:0];
			if (wr_scratch)
				scratch_reg <= data_reg;
			// Set wins over a clear in the same cycle
			cml_reg <= (bad_data_ev || bad_cmd_ev) ? 1'b1 : (do_clear ? 1'b0 : cml_reg);
			bad_data_reg <= bad_data_ev ? 1'b1 : (do_clear ? 1'b0 : bad_data_reg);
			bad_cmd_reg <= bad_cmd_ev ? 1'b1 : (do_clear ? 1'b0 : bad_cmd_reg);
			store_reg <= do_store;
			if (do_store)
			begin
				STORE_SCRATCH <= scratch_reg;
				STORE_TRIM <= trim_reg;
			end
		end
	end

	// Open-drain pins: only ever pull low
	assign SDA_OUT = 1'b0;
	assign SDA_OE = oe_reg;
	assign ALERT_OUT = 1'b0;
	assign ALERT_OE = cml_reg;
	assign STORE_PULSE = store_reg;
endmodule
`default_nettype wire

// >>> bench/host_model.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------------
// Bus host, 400 ns bus clock
// --------------------------
module host_model #(parameter logic [6:0] ADDR = 7'h24)
(
	// Clock
	input wire logic clk,
	// Bus wires
	output logic scl,
	output logic sda,
	input wire logic dev_oe
);
	logic host_low = 1'b0;
	logic [7:0] naks = 8'h00;
	// Pull-up: a released wire reads high
	assign sda = ~(host_low | dev_oe);
	// Bus clock stands high between frames
	initial scl = 1'b1;
	task automatic q(input int n);
		repeat (2 * n) @(negedge clk);
	endtask
	task automatic bitx(input logic b, output logic r);
		host_low = ~b;
		q(1);
		scl = 1'b1;
		q(1);
		r = sda;
		q(1);
		scl = 1'b0;
		q(1);
	endtask
	task automatic xbyte(input logic [7:0] d, input logic a, output logic [7:0] r, output logic k);
		for (int i = 7; i >= 0; i--)
			bitx(d[i], r[i]);
		bitx(a, k);
	endtask
	// Extra wait lets the device drop its acknowledge first
	task automatic start;
		host_low = 1'b0;
		q(2);
		scl = 1'b1;
		q(1);
		host_low = 1'b1;
		q(1);
		scl = 1'b0;
		q(1);
	endtask
	task automatic stop;
		host_low = 1'b1;
		q(1);
		scl = 1'b1;
		q(1);
		host_low = 1'b0;
		q(4);
	endtask
	task automatic head(input logic [7:0] a);
		logic [7:0] r;
		logic k;
		xbyte(a, 1'b1, r, k);
		naks += 8'(k);
	endtask
	task automatic wr(input logic [7:0] c, input logic [15:0] d, input int n);
		start;
		head({ADDR, 1'b0});
		head(c);
		if (n > 0)
			head(d[7:0]);
		if (n > 1)
			head(d[15:8]);
		stop;
	endtask
	// Raw codes only; calibration is not modelled
	task automatic rd(input logic [7:0] c, output logic [15:0] v);
		logic k;
		start;
		head({ADDR, 1'b0});
		head(c);
		start;
		head({ADDR, 1'b1});
		xbyte(8'hff, 1'b0, v[7:0], k);
		xbyte(8'hff, 1'b1, v[15:8], k);
		stop;
	endtask
	task automatic probe(input logic [6:0] a, output logic k);
		logic [7:0] r;
		start;
		xbyte({a, 1'b0}, 1'b1, r, k);
		stop;
	endtask
endmodule
`default_nettype wire

// >>> bench/telemetry_trim_registers_props.sv
`timescale 1ns/1ps
`default_nettype none
module telem_checker
	import telem_pkg::*;
#(parameter int CHANNELS = 2)
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RESETN,
	// Open-drain values
	input wire logic SDA_OUT,
	input wire logic ALERT_OUT,
	input wire logic ALERT_OE,
	// Reference control
	input wire logic [CHANNELS-1:0][15:0] MARGIN_STEP_SETTING,
	input wire logic [CHANNELS-1:0] SOFT_START_DONE,
	input wire logic [CHANNELS-1:0][15:0] REF_OFFSET,
	input wire logic [CHANNELS-1:0] RAMP_USE_TON_RISE,
	input wire logic [CHANNELS-1:0] RAMP_USE_SLOWEST,
	// Store
	input wire logic STORE_PULSE,
	input wire logic [15:0] STORE_SCRATCH,
	input wire logic [CHANNELS-1:0][15:0] STORE_TRIM
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);
	a_store_single_pulse: assert property (STORE_PULSE |=> !STORE_PULSE)
		else $error("store pulse too long");
	a_scratch_copy_hold: assert property (!STORE_PULSE |-> $stable(STORE_SCRATCH))
		else $error("scratch copy moved without store");
	a_trim_copy_hold: assert property (!STORE_PULSE |-> $stable(STORE_TRIM))
		else $error("trim copy moved without store");
	a_open_drain_low: assert property (!SDA_OUT && !ALERT_OUT)
		else $error("open-drain value not low");
	for (genvar c = 0; c < CHANNELS; c++)
	begin : g_ch
		a_slope_soft_start: assert property (RAMP_USE_TON_RISE[c] == !SOFT_START_DONE[c])
			else $error("rise slope select wrong");
		a_slope_after_start: assert property (RAMP_USE_SLOWEST[c] == SOFT_START_DONE[c])
			else $error("slowest slope select wrong");
		a_net_clamp_high: assert property
			($signed(MARGIN_STEP_SETTING[c]) > 90 |=> $signed(REF_OFFSET[c]) == NET_MAX) else $error("no high clamp");
		a_net_clamp_low: assert property
			($signed(MARGIN_STEP_SETTING[c]) < -150 |=> $signed(REF_OFFSET[c]) == NET_MIN) else $error("no low clamp");
		a_net_in_range: assert property
			($signed(REF_OFFSET[c]) <= NET_MAX && $signed(REF_OFFSET[c]) >= NET_MIN) else $error("offset out of range");
		a_net_alert: assert property ($signed(MARGIN_STEP_SETTING[c]) > 90 |-> ##[1:3] ALERT_OE)
			else $error("no alert on net overrange");
	end
endmodule
bind telemetry_trim_registers telem_checker #(.CHANNELS(CHANNELS)) telem_checker_inst (.CLK, .RESETN, .SDA_OUT,
	.ALERT_OUT, .ALERT_OE, .MARGIN_STEP_SETTING, .SOFT_START_DONE, .REF_OFFSET, .RAMP_USE_TON_RISE,
	.RAMP_USE_SLOWEST, .STORE_PULSE, .STORE_SCRATCH, .STORE_TRIM);
`default_nettype wire

// >>> bench/telemetry_trim_registers_bench.sv
`timescale 1ns/1ps
`default_nettype none
module telemetry_trim_registers_bench
	import telem_pkg::*;
;
	// Arbitrary value
	localparam logic [7:0] REV = 8'h3c;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic scl, sda, sda_oe, alert_oe, k;
	logic [1:0] iv = 2'b00, ineg = 2'b00, tv = 2'b00, ssd = 2'b00, ton, slow;
	logic [1:0][9:0] icode = '0;
	logic [1:0][10:0] tcode = '0;
	logic [1:0][15:0] margin = '0, ref_off, store_trim;
	logic [15:0] store_scratch, v;
	int fails = 0;
	int num_checks = 0;
	initial
	forever #25 clk = ~clk;
	host_model host_model_inst (.clk(clk), .scl(scl), .sda(sda), .dev_oe(sda_oe));
	telemetry_trim_registers #(.REVISION_CODE(REV)) telemetry_trim_registers_inst (.CLK(clk), .RESETN(rst_n),
		.SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(sda_oe), .ALERT_OUT(), .ALERT_OE(alert_oe),
		.IOUT_VALID(iv), .IOUT_CODE(icode), .IOUT_NEGATIVE(ineg), .TEMP_VALID(tv), .TEMP_CODE(tcode),
		.MARGIN_STEP_SETTING(margin), .SOFT_START_DONE(ssd), .REF_OFFSET(ref_off), .RAMP_USE_TON_RISE(ton),
		.RAMP_USE_SLOWEST(slow), .STORE_PULSE(), .STORE_SCRATCH(store_scratch), .STORE_TRIM(store_trim));
	task automatic end_of_test;
		if (fails == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e)
		begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic rchk(input logic [7:0] c, input logic [15:0] e);
		host_model_inst.rd(c, v);
		chk(v, e);
	endtask
	// -----------
	// Main sequence
	// -----------
	initial
	begin
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		rchk(CMD_OUTPUT_CURRENT, IOUT_RESET);
		rchk(CMD_EXT_TEMPERATURE, TEMP_RESET);
		rchk(CMD_PROTOCOL_REVISION, {8'h00, REV});
		rchk(CMD_USER_SCRATCH, SCRATCH_RESET);
		rchk(CMD_REF_TRIM, TRIM_RESET);
		icode = {10'h155, 10'h3ff};
		ineg = 2'b10;
		tcode = {11'h7ff, 11'h123};
		iv = 2'b11;
		tv = 2'b11;
		@(negedge clk);
		iv = 2'b00;
		tv = 2'b00;
		rchk(CMD_OUTPUT_CURRENT, {IOUT_EXPONENT, 1'b0, 10'h3ff});
		rchk(CMD_EXT_TEMPERATURE, {TEMP_EXPONENT, 11'h123});
		host_model_inst.wr(CMD_PAGE, 16'h0001, 1);
		rchk(CMD_OUTPUT_CURRENT, {IOUT_EXPONENT, 11'h000});
		rchk(CMD_EXT_TEMPERATURE, {TEMP_EXPONENT, 11'h7ff});
		host_model_inst.wr(CMD_USER_SCRATCH, 16'h1234, 2);
		host_model_inst.wr(CMD_PAGE, 16'h0000, 1);
		rchk(CMD_USER_SCRATCH, 16'h1234);
		host_model_inst.wr(CMD_REF_TRIM, 16'h001e, 2);
		chk(ref_off[0], 16'h001e);
		chk(16'(alert_oe), 16'h0000);
		host_model_inst.wr(CMD_PAGE, 16'h0001, 1);
		host_model_inst.wr(CMD_REF_TRIM, 16'h001f, 2);
		rchk(CMD_REF_TRIM, TRIM_MAX[15:0]);
		chk(16'(alert_oe), 16'h0001);
		rchk(CMD_STATUS_CML, 16'(1 << STATUS_CML_BAD_DATA_BIT));
		rchk(CMD_STATUS_BYTE, 16'(1 << STATUS_BYTE_CML_BIT));
		host_model_inst.wr(CMD_REF_TRIM, 16'hffc3, 2);
		rchk(CMD_REF_TRIM, TRIM_MIN[15:0]);
		host_model_inst.wr(CMD_CLEAR_FAULTS, 16'h0000, 0);
		chk(16'(alert_oe), 16'h0000);
		host_model_inst.wr(CMD_STORE_USER_ALL, 16'h0000, 0);
		chk(store_scratch, 16'h1234);
		chk(store_trim[0], 16'h001e);
		chk(store_trim[1], TRIM_MIN[15:0]);
		// Margin drives both ends past the net limits
		margin = {16'hff69, 16'h005f};
		repeat (2) @(negedge clk);
		chk(ref_off[1], NET_MIN[15:0]);
		chk(ref_off[0], NET_MAX[15:0]);
		chk(16'(alert_oe), 16'h0001);
		margin = {16'hfff6, 16'h0000};
		repeat (2) @(negedge clk);
		chk(ref_off[1], 16'hffba);
		ssd = 2'b01;
		#1;
		chk({12'h000, ton, slow}, 16'h0009);
		host_model_inst.probe(7'h25, k);
		chk(16'(k), 16'h0001);
		rchk(8'h20, UNMAPPED_READ);
		// Unknown write command and a page past the last channel both raise flags
		host_model_inst.wr(CMD_CLEAR_FAULTS, 16'h0000, 0);
		chk(16'(alert_oe), 16'h0000);
		host_model_inst.wr(8'h20, 16'h0000, 1);
		rchk(CMD_STATUS_CML, 16'(1 << STATUS_CML_BAD_CMD_BIT));
		host_model_inst.wr(CMD_PAGE, 16'h0002, 1);
		rchk(CMD_PAGE, 16'h0001);
		rchk(CMD_STATUS_CML, 16'((1 << STATUS_CML_BAD_CMD_BIT) | (1 << STATUS_CML_BAD_DATA_BIT)));
		chk(16'(alert_oe), 16'h0001);
		chk({8'h00, host_model_inst.naks}, 16'h0000);
		end_of_test;
	end
	// Hang guard
	initial
	begin
		repeat (60000) @(posedge clk);
		fails++;
		$display("[ERR] %0t timeout", $time);
		end_of_test;
	end
endmodule
`default_nettype wire
